//--- bfcr_pkg.sv
// Purpose: Shared constants of the bit framing and collision register bank.
// Assumes: 8-bit register port with 6-bit register addresses.
// Notes:   All offsets, field positions, reset values and state codes live here.
package bfcr_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFF_TIMER_RX  = 6'h0C;
    localparam logic [5:0] OFF_FRAME_ADJ = 6'h0D;
    localparam logic [5:0] OFF_COLL_REP  = 6'h0E;
    localparam logic [5:0] OFF_SPARE_A   = 6'h0F;
    localparam logic [5:0] OFF_SPARE_B   = 6'h10;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int BIT_HALT      = 7;
    localparam int BIT_GO        = 6;
    localparam int BIT_LAUNCH    = 7;
    localparam int ALIGN_HI      = 6;
    localparam int ALIGN_LO      = 4;
    localparam int BIT_KEEP      = 7;
    localparam int BIT_POS_INVAL = 5;
    localparam logic [2:0] TIMER_RX_RSVD = 3'h2;
    localparam logic [7:0] SPARE_RESET   = 8'h00;
    localparam logic       KEEP_RESET    = 1'h1;
    localparam logic [2:0] ALIGN_RESET   = 3'h0;
    localparam logic [2:0] TXBITS_RESET  = 3'h0;
    localparam logic [5:0] CLASH_MAX_POS = 6'h20;

    // ************************************************************
    // Modem state codes
    // ************************************************************
    localparam logic [2:0] MODEM_IDLE  = 3'h0;
    localparam logic [2:0] MODEM_WAIT  = 3'h1;
    localparam logic [2:0] MODEM_TX    = 3'h3;
    localparam logic [2:0] MODEM_RX    = 3'h6;

    typedef enum {
        ST_IDLE,
        ST_WAIT_LAUNCH,
        ST_TRANSMIT,
        ST_RECEIVE
    } bfcr_modem_e;
endpackage

//--- bfcr_fifo_mem.sv
// Purpose: Storage array of the receive FIFO.
// Assumes: One write and one read port, both on clk.
// Notes:   Read data come out of a register one cycle after the read.
`timescale 1ns/1ps
module bfcr_fifo_mem #(
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic          clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // bfcr_fifo_mem

//--- bfcr_bit_packer.sv
// Purpose: Packs serial received bits into bytes at a chosen start position.
// Assumes: frame_start comes before the first bit of a frame.
// Notes:   A partial last byte is pushed at frame_end.
`timescale 1ns/1ps
module bfcr_bit_packer (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [2:0] start_pos,
    input  wire logic       frame_start,
    input  wire logic       frame_end,
    input  wire logic       bit_valid,
    input  wire logic       bit_data,
    output logic            push_valid,
    output logic      [7:0] push_byte,
    output logic      [2:0] last_bits
);
    logic [7:0] shreg;
    logic [2:0] pos;
    logic [7:0] ins_byte;

    // Each lane takes the new bit only when the write position points at it.
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_lane
            assign ins_byte[i] = (pos == 3'(i)) ? bit_data : shreg[i];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            shreg      <= 8'h00;
            pos        <= 3'h0;
            push_valid <= 1'b0;
            push_byte  <= 8'h00;
            last_bits  <= 3'h0;
        end else begin
            push_valid <= 1'b0;
            if (frame_start) begin
                shreg <= 8'h00;
                pos   <= start_pos;
            end else if (bit_valid) begin
                if (pos == 3'h7) begin
                    push_valid <= 1'b1;
                    push_byte  <= ins_byte;
                    shreg      <= 8'h00;
                end else begin
                    shreg <= ins_byte;
                end
                pos <= pos + 3'h1;
            end else if (frame_end) begin
                last_bits <= pos;
                if (pos != 3'h0) begin
                    push_valid <= 1'b1;
                    push_byte  <= shreg;
                end
            end
        end
    end
endmodule // bfcr_bit_packer

//--- bfcr_regs.sv
// Purpose: Timer strobes, bit framing and collision report registers.
// Assumes: Register port and receiver/transmitter events are synchronous to clk.
// Notes:   Received bits are packed and kept in an internal FIFO.
`timescale 1ns/1ps

// Functional notes
// - Writing one to control bit 7 halts the timer; reads as zero.
// - Writing one to control bit 6 starts the timer; reads as zero.
// - Control bits 2..0 report valid bits of last received byte, zero meaning all.
// - Framing bit 7 write launches transmission only while send-then-receive is active.
// - Framing bits 6..4 set FIFO position of the first received bit.
// - Framing bits 2..0 set bits sent of the final byte, zero meaning eight.
// - Collision bit 7 low makes the receiver clear all bits after a collision.
// - Collision bit 5 reads one when no collision or position out of range.
// - Collision bits 4..0 give first collision data bit position, 00h meaning 32.
// - Registers 0Fh and 10h are reserved and read 00h.
// - Modem state reports 001 while waiting for the transmit launch.
// - Received bits, aligned, are stored into the internal 64-byte FIFO.
module bfcr_regs #(
    parameter int FIFO_DEPTH = 64
) (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic [bfcr_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                       reg_wr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_rd,
    output logic      [7:0]                 reg_rdata,
    input  wire logic                       transceive_active,
    input  wire logic                       tx_done,
    input  wire logic                       rx_frame_start,
    input  wire logic                       rx_frame_end,
    input  wire logic                       rx_bit_valid,
    input  wire logic                       rx_bit,
    input  wire logic                       clash_detect,
    input  wire logic [5:0]                 clash_bit_index,
    input  wire logic                       fifo_rd,
    output logic      [7:0]                 fifo_rd_data,
    output logic      [6:0]                 fifo_level,
    output logic                            fifo_overflow,
    output logic                            timer_halt_strobe,
    output logic                            timer_go_strobe,
    output logic                            transmit_launch,
    output logic      [2:0]                 rx_first_bit_offset,
    output logic      [2:0]                 tx_final_bit_count,
    output logic                            keep_bits_after_clash,
    output logic      [2:0]                 modem_fsm_state
);
    localparam int AW = $clog2(FIFO_DEPTH);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // The level field is seven bits wide, so deeper FIFOs cannot be reported.
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64 || (1 << AW) != FIFO_DEPTH) begin : g_bad_depth
        $error("FIFO_DEPTH must be a power of two from 2 to 64.");
    end

    // ************************************************************
    // Register decode
    // ************************************************************
    wire logic wr_timer = reg_wr && (reg_addr == bfcr_pkg::OFF_TIMER_RX);
    wire logic wr_frame = reg_wr && (reg_addr == bfcr_pkg::OFF_FRAME_ADJ);
    wire logic wr_coll  = reg_wr && (reg_addr == bfcr_pkg::OFF_COLL_REP);

    logic [2:0] rx_last_bits;
    logic       clash_pos_invalid;
    logic [4:0] clash_position;
    logic       clash_seen;

    // Reserved bits read as zero except the fixed pattern of the control register.
    wire logic [7:0] rd_timer = {2'b00, bfcr_pkg::TIMER_RX_RSVD, rx_last_bits};
    wire logic [7:0] rd_frame = {1'b0, rx_first_bit_offset, 1'b0, tx_final_bit_count};
    wire logic [7:0] rd_coll  = {keep_bits_after_clash, 1'b0, clash_pos_invalid,
                                 clash_position};
    wire logic [7:0] rd_mux   =
        (reg_addr == bfcr_pkg::OFF_TIMER_RX)  ? rd_timer :
        (reg_addr == bfcr_pkg::OFF_FRAME_ADJ) ? rd_frame :
        (reg_addr == bfcr_pkg::OFF_COLL_REP)  ? rd_coll  :
        bfcr_pkg::SPARE_RESET;

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    // ************************************************************
    // Writable fields and strobes
    // ************************************************************
    // Only the writable fields are loaded; status fields have their own drivers.
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_first_bit_offset   <= bfcr_pkg::ALIGN_RESET;
            tx_final_bit_count    <= bfcr_pkg::TXBITS_RESET;
            keep_bits_after_clash <= bfcr_pkg::KEEP_RESET;
        end else begin
            if (wr_frame) begin
                rx_first_bit_offset <= reg_wdata[bfcr_pkg::ALIGN_HI:bfcr_pkg::ALIGN_LO];
                tx_final_bit_count  <= reg_wdata[2:0];
            end
            if (wr_coll) begin
                keep_bits_after_clash <= reg_wdata[bfcr_pkg::BIT_KEEP];
            end
        end
    end

    wire logic launch_req = wr_frame && reg_wdata[bfcr_pkg::BIT_LAUNCH]
                            && transceive_active;

    always_ff @(posedge clk) begin
        if (srst) begin
            timer_halt_strobe <= 1'b0;
            timer_go_strobe   <= 1'b0;
            transmit_launch   <= 1'b0;
        end else begin
            timer_halt_strobe <= wr_timer && reg_wdata[bfcr_pkg::BIT_HALT];
            timer_go_strobe   <= wr_timer && reg_wdata[bfcr_pkg::BIT_GO];
            transmit_launch   <= launch_req;
        end
    end

    // ************************************************************
    // Modem state
    // ************************************************************
    bfcr_pkg::bfcr_modem_e state;
    bfcr_pkg::bfcr_modem_e next_state;

    always_comb begin
        next_state = state;
        case (state)
            bfcr_pkg::ST_IDLE: begin
                if (transceive_active) begin
                    next_state = bfcr_pkg::ST_WAIT_LAUNCH;
                end
            end
            bfcr_pkg::ST_WAIT_LAUNCH: begin
                if (launch_req) begin
                    next_state = bfcr_pkg::ST_TRANSMIT;
                end
            end
            bfcr_pkg::ST_TRANSMIT: begin
                if (tx_done) begin
                    next_state = bfcr_pkg::ST_RECEIVE;
                end
            end
            bfcr_pkg::ST_RECEIVE: begin
                if (rx_frame_end) begin
                    next_state = bfcr_pkg::ST_WAIT_LAUNCH;
                end
            end
            default: begin
                next_state = bfcr_pkg::ST_IDLE;
            end
        endcase
        // Dropping the command aborts the exchange from any state.
        if (!transceive_active) begin
            next_state = bfcr_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= bfcr_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign modem_fsm_state =
        (state == bfcr_pkg::ST_WAIT_LAUNCH) ? bfcr_pkg::MODEM_WAIT :
        (state == bfcr_pkg::ST_TRANSMIT)    ? bfcr_pkg::MODEM_TX   :
        (state == bfcr_pkg::ST_RECEIVE)     ? bfcr_pkg::MODEM_RX   :
        bfcr_pkg::MODEM_IDLE;

    // ************************************************************
    // Collision capture
    // ************************************************************
    wire logic first_clash = clash_detect && !clash_seen;
    wire logic pos_in_range = (clash_bit_index != 6'h00)
                              && (clash_bit_index <= bfcr_pkg::CLASH_MAX_POS);

    // A clash in the same cycle as a new frame start still counts for that frame.
    always_ff @(posedge clk) begin
        if (srst) begin
            clash_seen        <= 1'b0;
            clash_pos_invalid <= 1'b1;
            clash_position    <= 5'h00;
        end else if (rx_frame_start) begin
            clash_seen        <= clash_detect;
            clash_pos_invalid <= !(clash_detect && pos_in_range);
            clash_position    <= clash_detect ? clash_bit_index[4:0] : 5'h00;
        end else if (first_clash) begin
            clash_seen        <= 1'b1;
            clash_pos_invalid <= !pos_in_range;
            clash_position    <= clash_bit_index[4:0];
        end
    end

    // ************************************************************
    // Receive packing and FIFO
    // ************************************************************
    // Bits after the clash are zeroed, including the clashing bit itself.
    wire logic clearing  = !keep_bits_after_clash && (clash_seen || clash_detect);
    wire logic bit_eff   = rx_bit && !clearing;

    logic       push_valid;
    logic [7:0] push_byte;

    bfcr_bit_packer u_packer (
        .clk         (clk),
        .srst        (srst),
        .start_pos   (rx_first_bit_offset),
        .frame_start (rx_frame_start),
        .frame_end   (rx_frame_end),
        .bit_valid   (rx_bit_valid),
        .bit_data    (bit_eff),
        .push_valid  (push_valid),
        .push_byte   (push_byte),
        .last_bits   (rx_last_bits)
    );

    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire logic [AW:0] used   = wr_ptr - rd_ptr;
    wire logic        full   = used[AW];
    wire logic        empty  = (used == '0);
    wire logic        do_wr  = push_valid && !full;
    wire logic        do_rd  = fifo_rd && !empty;

    assign fifo_level = 7'(used);

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr        <= '0;
            rd_ptr        <= '0;
            fifo_overflow <= 1'b0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + (AW+1)'(1);
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + (AW+1)'(1);
            end
            // Sticky: a byte lost to a full FIFO is reported until reset.
            if (push_valid && full) begin
                fifo_overflow <= 1'b1;
            end
        end
    end

    bfcr_fifo_mem #(
        .DEPTH (FIFO_DEPTH),
        .AW    (AW)
    ) u_mem (
        .clk     (clk),
        .wr_en   (do_wr),
        .wr_addr (wr_ptr[AW-1:0]),
        .wr_data (push_byte),
        .rd_en   (do_rd),
        .rd_addr (rd_ptr[AW-1:0]),
        .rd_data (fifo_rd_data)
    );
endmodule // bfcr_regs

//--- bfcr_regs_monitor.sv
// Purpose: Port checker for the framing and collision register bank.
// Assumes: Bound to bfcr_regs; srst is synchronous and active high.
// Notes:   Strobes and read data follow their request by one edge.
`timescale 1ns/1ps
module bfcr_regs_monitor #(
    parameter int FIFO_DEPTH = 64
) (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic [5:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       transceive_active,
    input wire logic       timer_halt_strobe,
    input wire logic       timer_go_strobe,
    input wire logic       transmit_launch,
    input wire logic [2:0] rx_first_bit_offset,
    input wire logic [2:0] tx_final_bit_count,
    input wire logic       keep_bits_after_clash,
    input wire logic [2:0] modem_fsm_state
);
    // ****************************************
    // Decodes and assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire wr_ctl = reg_wr && reg_addr == bfcr_pkg::OFF_TIMER_RX;
    wire wr_frm = reg_wr && reg_addr == bfcr_pkg::OFF_FRAME_ADJ;
    wire wr_col = reg_wr && reg_addr == bfcr_pkg::OFF_COLL_REP;
    wire wait_l = modem_fsm_state == bfcr_pkg::MODEM_WAIT;
    wire rd_spr = reg_rd && (reg_addr == 6'h0F || reg_addr == 6'h10);
    a_halt_pulse: assert property (!$past(srst) |->
        timer_halt_strobe == $past(wr_ctl && reg_wdata[7])) else $error("halt strobe wrong");
    a_go_pulse: assert property (!$past(srst) |->
        timer_go_strobe == $past(wr_ctl && reg_wdata[6])) else $error("go strobe wrong");
    a_launch_cause: assert property (transmit_launch |->
        $past(wr_frm && reg_wdata[7] && transceive_active)) else $error("stray launch");
    a_launch_taken: assert property (wr_frm && reg_wdata[7] && transceive_active && wait_l
        |=> transmit_launch) else $error("launch missing");
    a_wait_entry: assert property ($rose(transceive_active) &&
        modem_fsm_state == bfcr_pkg::MODEM_IDLE |=> wait_l) else $error("no wait state");
    a_frame_fields: assert property (wr_frm |=> rx_first_bit_offset ==
        $past(reg_wdata[6:4]) && tx_final_bit_count == $past(reg_wdata[2:0]))
        else $error("framing fields wrong");
    a_fields_hold: assert property (!wr_frm |=> $stable(rx_first_bit_offset) &&
        $stable(tx_final_bit_count)) else $error("framing fields moved");
    a_keep_field: assert property (!$past(srst) |-> keep_bits_after_clash ==
        ($past(wr_col) ? $past(reg_wdata[7]) : $past(keep_bits_after_clash)))
        else $error("keep bit wrong");
    a_ctrl_read: assert property (reg_rd && reg_addr == bfcr_pkg::OFF_TIMER_RX |=>
        reg_rdata[7:3] == {2'h0, bfcr_pkg::TIMER_RX_RSVD}) else $error("control read wrong");
    a_spare_read: assert property (rd_spr |=> reg_rdata == 8'h00)
        else $error("spare register not zero");
endmodule // bfcr_regs_monitor
bind bfcr_regs bfcr_regs_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) bfcr_regs_monitor_i (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .transceive_active(transceive_active),
    .timer_halt_strobe(timer_halt_strobe), .timer_go_strobe(timer_go_strobe),
    .transmit_launch(transmit_launch), .rx_first_bit_offset(rx_first_bit_offset),
    .tx_final_bit_count(tx_final_bit_count), .keep_bits_after_clash(keep_bits_after_clash),
    .modem_fsm_state(modem_fsm_state));

//--- bfcr_regs_bench.sv
// Purpose: Self-checking bench of the framing and collision register bank.
// Assumes: Register reads answer one edge after reg_rd.
// Notes:   Bits are sent one per cycle; collisions ride on a chosen bit.
`timescale 1ns/1ps
module bfcr_regs_bench;
    logic       clk, srst, reg_wr, reg_rd, transceive_active, tx_done, fifo_rd;
    logic       rx_frame_start, rx_frame_end, rx_bit_valid, rx_bit, clash_detect;
    logic [5:0] reg_addr, clash_bit_index;
    logic [7:0] reg_wdata, reg_rdata, fifo_rd_data;
    logic [6:0] fifo_level;
    logic       fifo_overflow, timer_halt_strobe, timer_go_strobe, transmit_launch, keep;
    logic [2:0] rx_first_bit_offset, tx_final_bit_count, modem_fsm_state;
    int         n_errors, cmp_count, cycles;
    bfcr_regs bfcr_regs_i (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .transceive_active(transceive_active), .tx_done(tx_done),
        .rx_frame_start(rx_frame_start), .rx_frame_end(rx_frame_end),
        .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .clash_detect(clash_detect),
        .clash_bit_index(clash_bit_index), .fifo_rd(fifo_rd), .fifo_rd_data(fifo_rd_data),
        .fifo_level(fifo_level), .fifo_overflow(fifo_overflow),
        .timer_halt_strobe(timer_halt_strobe), .timer_go_strobe(timer_go_strobe),
        .transmit_launch(transmit_launch), .rx_first_bit_offset(rx_first_bit_offset),
        .tx_final_bit_count(tx_final_bit_count), .keep_bits_after_clash(keep),
        .modem_fsm_state(modem_fsm_state));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic read_check(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    task automatic pop_check(input logic [7:0] exp);
        @(posedge clk);
        fifo_rd <= 1'b1;
        @(posedge clk);
        fifo_rd <= 1'b0;
        #1 check(fifo_rd_data, exp);
    endtask
    // Bit two of every frame is zero so that placement is visible.
    task automatic rx_frame(input int n, input int cat, input logic [5:0] cidx);
        @(posedge clk);
        rx_frame_start <= 1'b1;
        clash_bit_index <= cidx;
        for (int i = 1; i <= n; i++) begin
            @(posedge clk);
            rx_frame_start <= 1'b0;
            rx_bit_valid <= 1'b1;
            rx_bit <= (i != 2);
            clash_detect <= (i == cat);
        end
        @(posedge clk);
        rx_frame_start <= 1'b0;
        rx_bit_valid <= 1'b0;
        clash_detect <= 1'b0;
        @(posedge clk);
        rx_frame_end <= 1'b1;
        @(posedge clk);
        rx_frame_end <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic modem_check(input logic [7:0] exp);
        check({transmit_launch, 4'h0, modem_fsm_state}, exp);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_and_spare();
        read_check(6'h0C, 8'h10);
        read_check(6'h0E, 8'hA0);
        reg_write(6'h0F, 8'hFF);
        reg_write(6'h10, 8'hFF);
        read_check(6'h0F, 8'h00);
        read_check(6'h10, 8'h00);
        read_check(6'h3F, 8'h00);
    endtask
    task automatic t_strobes();
        reg_write(6'h0C, 8'hC0);
        check({6'h0, timer_halt_strobe, timer_go_strobe}, 8'h03);
        reg_write(6'h0C, 8'h3F);
        check({6'h0, timer_halt_strobe, timer_go_strobe}, 8'h00);
        read_check(6'h0C, 8'h10);
    endtask
    task automatic t_framing();
        for (int i = 0; i < 8; i++) begin
            reg_write(6'h0D, {1'b0, 3'(i), 1'b1, 3'(i)});
            check({2'h0, rx_first_bit_offset, tx_final_bit_count}, {2'h0, 3'(i), 3'(i)});
            read_check(6'h0D, {1'b0, 3'(i), 1'b0, 3'(i)});
        end
    endtask
    task automatic t_launch_receive();
        reg_write(6'h0D, 8'hB0);
        modem_check(8'h00);
        @(posedge clk) transceive_active <= 1'b1;
        @(posedge clk) #1 modem_check(8'h01);
        reg_write(6'h0D, 8'hB0);
        modem_check(8'h83);
        @(posedge clk) tx_done <= 1'b1;
        @(posedge clk) tx_done <= 1'b0;
        #1 modem_check(8'h06);
        rx_frame(10, 4, 6'h04);
        modem_check(8'h01);
        read_check(6'h0C, 8'h15);
        read_check(6'h0E, 8'h84);
        check({1'h0, fifo_level}, 8'h02);
        pop_check(8'hE8);
        pop_check(8'h1F);
        check({fifo_overflow, fifo_level}, 8'h00);
        @(posedge clk) transceive_active <= 1'b0;
        @(posedge clk) #1 modem_check(8'h00);
    endtask
    task automatic t_clash();
        reg_write(6'h0E, 8'h00);
        check({7'h00, keep}, 8'h00);
        reg_write(6'h0D, 8'h00);
        rx_frame(4, 3, 6'h03);
        read_check(6'h0C, 8'h14);
        read_check(6'h0E, 8'h03);
        pop_check(8'h01);
        reg_write(6'h0E, 8'h80);
        rx_frame(1, 1, 6'h20);
        read_check(6'h0E, 8'h80);
        rx_frame(1, 1, 6'h21);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= 6'h0E;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata & 8'hA0, 8'hA0);
    endtask
    // Sixty-five full bytes overrun the FIFO; a mid-run reset must clear the sticky flag.
    task automatic t_overflow();
        rx_frame(520, 0, 6'h00);
        check({fifo_overflow, fifo_level}, 8'hC0);
        read_check(6'h0C, 8'h10);
        @(posedge clk) srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1 check({fifo_overflow, fifo_level}, 8'h00);
        read_check(6'h0E, 8'hA0);
        read_check(6'h0D, 8'h00);
    endtask
    // ****************************************
    // Clock, watchdog and main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 4000) begin
                n_errors++;
                final_report();
            end
        end
    end
    initial begin
        {reg_wr, reg_rd, transceive_active, tx_done, fifo_rd, rx_frame_start} = '0;
        {rx_frame_end, rx_bit_valid, rx_bit, clash_detect} = '0;
        {reg_addr, clash_bit_index, reg_wdata} = '0;
        n_errors = 0;
        cmp_count = 0;
        srst = 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        t_reset_and_spare();
        t_strobes();
        t_framing();
        t_launch_receive();
        t_clash();
        t_overflow();
        final_report();
    end
endmodule // bfcr_regs_bench
